// ==== core/dsb2_pkg.sv ====
// dsb2 package: widths, timing counts and impedance settings
package dsb2_pkg;
    // bus shape (18-bit variant by default)
    localparam int DSB2_DATA_W = 18;
    localparam int DSB2_LANE_W = 9;
    localparam int DSB2_LANES = DSB2_DATA_W / DSB2_LANE_W;
    localparam int DSB2_ADDR_W = 6;
    // nybble variant lane width
    localparam int DSB2_NYB_W = 4;
    // impedance calibration
    localparam int DSB2_IMP_W = 4;
    localparam logic [DSB2_IMP_W-1:0] DSB2_IMP_MIN = 4'h0;
    localparam logic [DSB2_IMP_W-1:0] DSB2_IMP_RST = 4'h8;
    localparam int DSB2_CAL_PERIOD = 1024;
    // link clock divider: half period in system clocks
    localparam int DSB2_LINK_HALF = 8;
    // fifo
    localparam int DSB2_FIFO_DEPTH = 8;
endpackage : dsb2_pkg

// ==== core/dsb2_if.sv ====
// dsb2 interface: pins between memory controller and sram
`timescale 1ns/1ns
`default_nettype none
interface dsb2_if #(
    parameter int DW = dsb2_pkg::DSB2_DATA_W,
    parameter int AW = dsb2_pkg::DSB2_ADDR_W,
    parameter int LN = dsb2_pkg::DSB2_LANES
);
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic rd_n;
    logic wr_n;
    logic [AW-1:0] addr_bus;
    logic [DW-1:0] in_bus;
    logic [LN-1:0] lane_mask_n;
    logic [DW-1:0] out_bus;
    logic out_oe;
    modport ctrl (
        output k, k_n, c, c_n, rd_n, wr_n, addr_bus, in_bus, lane_mask_n,
        input out_bus, out_oe
    );
    modport sram (
        input k, k_n, c, c_n, rd_n, wr_n, addr_bus, in_bus, lane_mask_n,
        output out_bus, out_oe
    );
endinterface : dsb2_if
`default_nettype wire

// ==== core/dsb2_fifo.sv ====
// dsb2 fifo: parameterised valid/ready buffer
`timescale 1ns/1ns
`default_nettype none
module dsb2_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : dsb2_fifo
`default_nettype wire

// ==== core/dsb2_sram.sv ====
// dsb2 sram end: ddr burst-of-2 separate-io memory model in logic
`timescale 1ns/1ns
`default_nettype none
module dsb2_sram
    import dsb2_pkg::*;
#(
    parameter int DW = DSB2_DATA_W,
    parameter int AW = DSB2_ADDR_W,
    parameter int LW = DSB2_LANE_W,
    parameter int CAL_PERIOD = DSB2_CAL_PERIOD
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the controller
    dsb2_if.sram link,
    // impedance calibration
    input wire logic imped_set_pin,
    input wire logic imped_ref_res,
    output logic [DSB2_IMP_W-1:0] imped_code
);
    import dsb2_pkg::*;
    localparam int LN = DW / LW;
    localparam int DEPTH = 1 << AW;

    // two-flop synchronisers for all pins
    logic [3:0] ck_s1_q;
    logic [3:0] ck_s2_q;
    logic [3:0] ck_s3_q;
    logic rd_s1_q, rd_s2_q, wr_s1_q, wr_s2_q;
    logic [AW-1:0] a_s1_q, a_s2_q;
    logic [DW-1:0] d_s1_q, d_s2_q;
    logic [LN-1:0] m_s1_q, m_s2_q;
    logic zq_s1_q, zq_s2_q, rq_s1_q, rq_s2_q;
    always_ff @(posedge clk) begin
        ck_s1_q <= {link.c_n, link.c, link.k_n, link.k};
        ck_s2_q <= ck_s1_q;
        ck_s3_q <= ck_s2_q;
        rd_s1_q <= link.rd_n;
        rd_s2_q <= rd_s1_q;
        wr_s1_q <= link.wr_n;
        wr_s2_q <= wr_s1_q;
        a_s1_q <= link.addr_bus;
        a_s2_q <= a_s1_q;
        d_s1_q <= link.in_bus;
        d_s2_q <= d_s1_q;
        m_s1_q <= link.lane_mask_n;
        m_s2_q <= m_s1_q;
        zq_s1_q <= imped_set_pin;
        zq_s2_q <= zq_s1_q;
        rq_s1_q <= imped_ref_res;
        rq_s2_q <= rq_s1_q;
    end

    // edge detection on the synchronised strobes
    logic k_rise, kn_rise, c_rise, cn_rise, c_parked;
    assign k_rise = ck_s2_q[0] && !ck_s3_q[0];
    assign kn_rise = ck_s2_q[1] && !ck_s3_q[1];
    assign c_rise = ck_s2_q[2] && !ck_s3_q[2];
    assign cn_rise = ck_s2_q[3] && !ck_s3_q[3];
    // both output strobes high for more than two k periods means tied high
    logic [7:0] c_hi_cnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c_hi_cnt_q <= 8'h00;
        end else if (!(ck_s2_q[2] && ck_s2_q[3])) begin
            c_hi_cnt_q <= 8'h00;
        end else if (c_hi_cnt_q != 8'hff) begin
            c_hi_cnt_q <= c_hi_cnt_q + 8'h01;
        end
    end
    assign c_parked = (c_hi_cnt_q > 8'(4 * DSB2_LINK_HALF));
    logic fire0, fire1;
    // beat0 fires on c_n rise, or k_n when parked; beat1 on c or k
    assign fire0 = c_parked ? kn_rise : cn_rise;
    assign fire1 = c_parked ? k_rise : c_rise;

    // array, each word two beats wide
    logic [2*DW-1:0] mem_q [DEPTH];
    logic wr_pend_q;
    logic [DW-1:0] wd0_q;
    logic [LN-1:0] wm0_q;
    logic rd_pend_q;
    logic [AW-1:0] ra_q;

    // command and first beat capture at k rise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ra_q <= '0;
            wd0_q <= '0;
            wm0_q <= '1;
        end else if (k_rise) begin
            rd_pend_q <= !rd_s2_q;
            ra_q <= a_s2_q;
            wr_pend_q <= !wr_s2_q;
            wd0_q <= d_s2_q;
            wm0_q <= m_s2_q;
        end else if (kn_rise) begin
            wr_pend_q <= 1'b0;
        end
    end

    // second beat and address at k_n rise merge into the array
    logic [2*DW-1:0] wr_word;
    logic [2*DW-1:0] old_word;
    logic [AW-1:0] wa;
    assign wa = a_s2_q;
    assign old_word = mem_q[wa];
    for (genvar g = 0; g < LN; g++) begin : g_lane
        // a lane is kept per beat when its mask was high
        assign wr_word[g*LW +: LW] = wm0_q[g] ? old_word[g*LW +: LW]
            : wd0_q[g*LW +: LW];
        assign wr_word[DW+g*LW +: LW] = m_s2_q[g] ?
            old_word[DW+g*LW +: LW] : d_s2_q[g*LW +: LW];
    end
    logic wr_go;
    assign wr_go = kn_rise && wr_pend_q;
    always_ff @(posedge clk) begin
        if (wr_go) begin
            mem_q[wa] <= wr_word;
        end
    end

    // read access at k_n rise; a matching write in the same cycle is
    // passed through because the merged word is taken before storage
    logic [2*DW-1:0] rd_word_q;
    logic rd_live_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_word_q <= '0;
            rd_live_q <= 1'b0;
        end else if (kn_rise) begin
            rd_live_q <= rd_pend_q;
            if (wr_go && wa == ra_q) begin
                rd_word_q <= wr_word;
            end else begin
                rd_word_q <= mem_q[ra_q];
            end
        end
    end

    // output registers: beat0 then beat1, then release the bus
    logic [DW-1:0] q_q;
    logic [DW-1:0] q1_hold_q;
    logic oe_q;
    logic beat1_due_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_q <= '0;
            q1_hold_q <= '0;
            oe_q <= 1'b0;
            beat1_due_q <= 1'b0;
        end else if (fire0) begin
            q_q <= rd_word_q[DW-1:0];
            // the next read refills rd_word_q on this strobe: park beat1
            q1_hold_q <= rd_word_q[2*DW-1:DW];
            oe_q <= rd_live_q;
            beat1_due_q <= rd_live_q;
        end else if (fire1) begin
            q_q <= q1_hold_q;
            oe_q <= beat1_due_q;
            beat1_due_q <= 1'b0;
        end
    end
    assign link.out_bus = q_q;
    assign link.out_oe = oe_q;

    // impedance: periodic evaluation, one step toward the reference
    logic [31:0] cal_cnt_q;
    logic [DSB2_IMP_W-1:0] imp_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cal_cnt_q <= '0;
            imp_q <= DSB2_IMP_RST;
        end else if (zq_s2_q) begin
            imp_q <= DSB2_IMP_MIN;
            cal_cnt_q <= '0;
        end else if (cal_cnt_q == 32'(CAL_PERIOD - 1)) begin
            cal_cnt_q <= '0;
            // reference high means impedance too low: step up
            if (rq_s2_q && imp_q != '1) begin
                imp_q <= imp_q + 1'b1;
            end else if (!rq_s2_q && imp_q != '0) begin
                imp_q <= imp_q - 1'b1;
            end
        end else begin
            cal_cnt_q <= cal_cnt_q + 32'h1;
        end
    end
    assign imped_code = imp_q;
endmodule : dsb2_sram
`default_nettype wire

// ==== core/dsb2_ctrl.sv ====
// dsb2 controller end: drives strobes, commands and beats from a fifo
`timescale 1ns/1ns
`default_nettype none
module dsb2_ctrl
    import dsb2_pkg::*;
#(
    parameter int DW = DSB2_DATA_W,
    parameter int AW = DSB2_ADDR_W,
    parameter int LN = DSB2_LANES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins to the sram
    dsb2_if.ctrl link,
    // request stream: {is_wr, addr, mask1, data1, mask0, data0}
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2*DW+2*LN+AW:0] req_data,
    // output strobe mode: high parks c pair high
    input wire logic c_park,
    // read beats as seen on the bus
    output logic rd_valid,
    output logic [DW-1:0] rd_data
);
    import dsb2_pkg::*;
    localparam int RW = 2*DW + 2*LN + AW + 1;
    typedef enum logic [1:0] {
        DSB2_PH_K = 2'b01,
        DSB2_PH_KN = 2'b10
    } dsb2_ph_t;

    // request buffer; drained one per link cycle so it can fill
    logic f_valid, f_pop;
    logic [RW-1:0] f_data;
    dsb2_fifo #(.WIDTH(RW), .DEPTH(DSB2_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // strobe divider: k high half, k_n high the other half
    logic [7:0] div_q;
    dsb2_ph_t ph_q;
    logic edge_now;
    assign edge_now = (div_q == 8'(DSB2_LINK_HALF - 1));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 8'h00;
            ph_q <= DSB2_PH_KN;
        end else if (edge_now) begin
            div_q <= 8'h00;
            case (ph_q)
                DSB2_PH_K: ph_q <= DSB2_PH_KN;
                DSB2_PH_KN: ph_q <= DSB2_PH_K;
                default: ph_q <= DSB2_PH_K;
            endcase
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    // take a request when entering the k half
    assign f_pop = edge_now && ph_q == DSB2_PH_KN && f_valid;

    // second beat and its mask, held for the k_n half of the link cycle
    logic [DW+LN-1:0] hi_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_q <= '0;
        end else if (f_pop) begin
            hi_q <= f_data[DW+LN +: DW+LN];
        end
    end
    // command, address, beat0 and mask0 go out one clock ahead of the k
    // rise so they never change with the strobe; beat1 mid k half
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.k <= 1'b0;
            link.k_n <= 1'b0;
            link.c <= 1'b1;
            link.c_n <= 1'b1;
            link.rd_n <= 1'b1;
            link.wr_n <= 1'b1;
            link.addr_bus <= '0;
            link.in_bus <= '0;
            link.lane_mask_n <= '1;
        end else begin
            link.k <= (ph_q == DSB2_PH_K);
            link.k_n <= (ph_q == DSB2_PH_KN);
            link.c <= c_park | (ph_q == DSB2_PH_K);
            link.c_n <= c_park | (ph_q == DSB2_PH_KN);
            if (edge_now && ph_q == DSB2_PH_KN) begin
                link.rd_n <= !(f_valid && !f_data[RW-1]);
                link.wr_n <= !(f_valid && f_data[RW-1]);
                link.addr_bus <= f_data[RW-2 -: AW];
                link.in_bus <= f_data[DW-1:0];
                link.lane_mask_n <= f_data[DW +: LN];
            end else if (ph_q == DSB2_PH_K &&
                         div_q >= 8'(DSB2_LINK_HALF / 2)) begin
                link.in_bus <= hi_q[DW-1:0];
                link.lane_mask_n <= hi_q[DW +: LN];
            end
        end
    end

    // capture read beats while the sram drives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= link.out_oe && (div_q == 8'(DSB2_LINK_HALF - 1));
            rd_data <= link.out_bus;
        end
    end
endmodule : dsb2_ctrl
`default_nettype wire

// ==== verification/dsb2_asserts.sv ====
// dsb2 checker: link pin and impedance code assertions
`timescale 1ns/1ns
`default_nettype none
module dsb2_asserts
    import dsb2_pkg::*;
#(
    parameter int CAL_PERIOD = DSB2_CAL_PERIOD
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins
    input wire logic k,
    input wire logic k_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic out_oe,
    // impedance
    input wire logic imped_set_pin,
    input wire logic [DSB2_IMP_W-1:0] imped_code
);
    logic k_q;
    logic [6:0] rd_age_q;
    logic [15:0] imp_age_q;
    logic [DSB2_IMP_W-1:0] code_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    // age of last read taken at a k rise, saturating
    always_ff @(posedge clk) begin
        k_q <= k;
        if (!rst_n) begin
            rd_age_q <= 7'h7f;
        end else if (k && !k_q && !rd_n) begin
            rd_age_q <= 7'h00;
        end else if (rd_age_q != 7'h7f) begin
            rd_age_q <= rd_age_q + 7'h01;
        end
    end
    // cycles since the impedance code last moved
    always_ff @(posedge clk) begin
        code_q <= imped_code;
        if (!rst_n || imped_code != code_q) begin
            imp_age_q <= 16'h0000;
        end else if (imp_age_q != 16'hffff) begin
            imp_age_q <= imp_age_q + 16'h0001;
        end
    end
    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    chk_reset_idle: assert property (
        $rose(rst_n) |-> !out_oe && rd_n && wr_n)
        else $error("pins not idle after reset");
    chk_k_excl: assert property (
        !(k && k_n))
        else $error("k and k_n high together");
    chk_k_period: assert property (
        $rose(k) |-> k [*8] ##1 !k)
        else $error("k high phase not eight clocks");
    chk_oe_cause: assert property (
        $rose(out_oe) |-> rd_age_q < 7'd64)
        else $error("outputs driven without a read");
    chk_oe_release: assert property (
        out_oe |-> rd_age_q < 7'd80)
        else $error("outputs left driven after deselect");
    chk_beat_len: assert property (
        $rose(out_oe) |-> out_oe [*8])
        else $error("read beat window too short");
    chk_imp_step: assert property (
        $changed(imped_code) && !imped_set_pin && !$past(imped_set_pin)
        |-> DSB2_IMP_W'(imped_code - $past(imped_code)) inside {4'h1, 4'hf})
        else $error("impedance moved more than one step");
    chk_imp_period: assert property (
        $changed(imped_code) && !imped_set_pin && !$past(imped_set_pin)
        |-> imp_age_q >= 16'(CAL_PERIOD - 2))
        else $error("impedance evaluated too often");
    chk_imp_min: assert property (
        $rose(imped_set_pin) |-> ##[1:40] imped_code == DSB2_IMP_MIN)
        else $error("tied impedance pin not at minimum");
endmodule : dsb2_asserts
`default_nettype wire

// ==== verification/dsb2_tb.sv ====
// dsb2 testbench: controller and sram ends joined over the link
`timescale 1ns/1ns
`default_nettype none
module ddr_sram_burst2_port_tb;
    import dsb2_pkg::*;
    localparam int RW = 2 * DSB2_DATA_W + 2 * DSB2_LANES + DSB2_ADDR_W + 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [RW-1:0] req_data = '0;
    logic c_park = 1'b0;
    logic rd_valid;
    logic [DSB2_DATA_W-1:0] rd_data;
    logic imped_set_pin = 1'b0;
    logic imped_ref_res = 1'b1;
    logic [DSB2_IMP_W-1:0] imped_code;
    logic stall_seen = 1'b0;
    logic [DSB2_DATA_W-1:0] mem0 [64];
    logic [DSB2_DATA_W-1:0] mem1 [64];
    logic [DSB2_DATA_W-1:0] rq [$];
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // ---------------------------------------------
    // clock, parts and checker
    // ---------------------------------------------
    always #4 clk = ~clk;
    dsb2_if i_dsb2_if ();
    dsb2_ctrl i_dsb2_ctrl (.clk(clk), .rst_n(rst_n), .link(i_dsb2_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
        .c_park(c_park), .rd_valid(rd_valid), .rd_data(rd_data));
    // short calibration period keeps the run brief
    dsb2_sram #(.CAL_PERIOD(16)) i_dsb2_sram (.clk(clk), .rst_n(rst_n),
        .link(i_dsb2_if), .imped_set_pin(imped_set_pin),
        .imped_ref_res(imped_ref_res), .imped_code(imped_code));
    dsb2_asserts #(.CAL_PERIOD(16)) i_dsb2_asserts (.clk(clk),
        .rst_n(rst_n), .k(i_dsb2_if.k), .k_n(i_dsb2_if.k_n),
        .rd_n(i_dsb2_if.rd_n), .wr_n(i_dsb2_if.wr_n),
        .out_oe(i_dsb2_if.out_oe), .imped_set_pin(imped_set_pin),
        .imped_code(imped_code));
    // read beats sampled mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // masked lanes keep old contents, active low per lane
    function automatic logic [DSB2_DATA_W-1:0] merge(
        input logic [DSB2_DATA_W-1:0] old, input logic [DSB2_DATA_W-1:0] nw,
        input logic [DSB2_LANES-1:0] m);
        logic [DSB2_DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < DSB2_LANES; i++) begin
            if (!m[i]) r[i*DSB2_LANE_W +: DSB2_LANE_W] =
                nw[i*DSB2_LANE_W +: DSB2_LANE_W];
        end
        return r;
    endfunction : merge
    // request held until ready is seen; valid stays up for back to back
    task automatic push(input logic [RW-1:0] d);
        int n;
        n = 0;
        if (req_valid !== 1'b1) req_valid <= 1'b1;
        req_data <= d;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 500) begin
            stall_seen = 1'b1;
            n++;
            @(negedge clk);
        end
        if (n == 500) cmp("req_ready", 1, 0);
        @(posedge clk);
    endtask : push
    task automatic idle();
        req_valid <= 1'b0;
        @(posedge clk);
    endtask : idle
    task automatic do_write(input logic [5:0] a, input logic [1:0] m1,
        input logic [17:0] d1, input logic [1:0] m0, input logic [17:0] d0);
        push({1'b1, a, m1, d1, m0, d0});
        mem0[a] = merge(mem0[a], d0, m0);
        mem1[a] = merge(mem1[a], d1, m1);
    endtask : do_write
    task automatic do_read(input logic [5:0] a);
        int n;
        n = 0;
        push({1'b0, a, 40'h0});
        idle();
        while (rq.size() < 2 && n < 300) begin
            n++;
            @(negedge clk);
        end
        cmp("beats", 2, rq.size());
        if (rq.size() >= 2) begin
            cmp("beat0", mem0[a], rq.pop_front());
            cmp("beat1", mem1[a], rq.pop_front());
        end
        rq.delete();
        @(posedge clk);
    endtask : do_read
    task automatic results();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp("imped_code", DSB2_IMP_RST, imped_code);
        @(posedge clk);
        do_write(6'd1, 2'b00, 18'h2aaaa, 2'b00, 18'h15555);
        do_write(6'd2, 2'b00, 18'h3c0f0, 2'b00, 18'h0ff0f);
        do_write(6'd2, 2'b01, 18'h12345, 2'b10, 18'h2468a);
        do_write(6'd1, 2'b11, 18'h00000, 2'b11, 18'h3ffff);
        do_write(6'd63, 2'b00, 18'h00001, 2'b00, 18'h20000);
        idle();
        do_read(6'd1);
        do_read(6'd2);
        do_read(6'd63);
        c_park <= 1'b1;
        // let the sram see the parked output strobes before the read
        repeat (48) @(posedge clk);
        do_read(6'd2);
        c_park <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            do_write(6'(10 + i), 2'b00, 18'(i * 7), 2'b00, 18'(i * 3));
        end
        idle();
        cmp("fifo_full", 1, stall_seen);
        do_read(6'd10);
        do_read(6'd19);
        repeat (40) @(posedge clk);
        @(negedge clk);
        cmp("out_oe", 0, i_dsb2_if.out_oe);
        cmp("imped_code", 15, imped_code);
        @(posedge clk);
        imped_set_pin <= 1'b1;
        repeat (40) @(posedge clk);
        @(negedge clk);
        cmp("imped_code", DSB2_IMP_MIN, imped_code);
        results();
    end
endmodule : ddr_sram_burst2_port_tb
`default_nettype wire
